// >>> spmp_port.sv
/*
  Serial port, controller or target, with its AHB-Lite register slave.
  Assumes pins arrive asynchronously to hclk; the bench resolves the
  open lines from the enables. irq_mask_i is the CPU global mask bit.
*/
// Added by the designer: the address map and register access over AHB-Lite.
//
// Overview of operation
// - Bytes travel on the two data lines most significant bit first.
// - One shift register serves both directions; sent byte becomes received byte.
// - A byte is exactly eight clock pulses, one bit out and in each.
// - As controller the port makes the serial clock and drives it out.
// - Controller clock rate is one of four, picked by two rate bits.
// - As target the rate bits are unused; the received clock times shifting.
// - As controller, enable and controller bits hold only while select input stays high.
// - Controller drives out-line and samples in-line; target the reverse.
// - Controller data write loads the shift register and starts the byte.
// - Byte end sets done flag; interrupt if enabled and not globally masked.
// - At byte end received byte is buffered; data reads return the buffer.
// - Done flag clears by status access while set, then data read.
// - With done flag set, data writes are ignored until status is read or written.
// - Enable set and controller clear puts the pins into target mode.
// - Target starts on the controller's clock, shifting its byte out first.
// - Both ends use the same idle level and capture phase settings.
// - An unselected target ignores the clock and leaves its out-line undriven.
// - Idle level sets clock between bytes; phase picks first or second edge.
// - Data write during a byte is dropped and sets the clash flag only.
// - Select low as controller sets fault flag and clears enable and mode.
`timescale 1ns/100ps

module spmp_port (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  input  wire logic                       irq_mask_i,
  output logic                            irq,
  input  wire spmp_pkg::spmp_pin_in_type  pin_i,
  output spmp_pkg::spmp_pin_out_type      pin_o
);
  import spmp_pkg::*;

  logic [3:0]     sync1_r;
  logic [3:0]     sync2_r;
  logic           sck_d_r;
  logic [7:0]     ctrl_r;
  logic [7:0]     ctrl_nxt;
  logic           done_r;
  logic           write_clash_flag_r;
  logic           controller_fault_flag_r;
  logic           seen_r;
  logic           controller_fault_flag_arm_r;
  logic [7:0]     rxbuf_r;
  logic [7:0]     shift_r;
  logic           out_bit_r;
  logic [4:0]     edge_cnt_r;
  logic [7:0]     half_cnt_r;
  logic           sck_r;
  spmp_state_type state_r;
  logic [7:0]     addr_r;
  logic           wr_r;
  logic [7:0]     rdata_r;

  // Bus decode
  wire logic       ap      = hsel & htrans[1] & hready;
  wire logic       rd_ap   = ap & ~hwrite;
  wire logic [7:0] a_ofs   = haddr[7:0];
  wire logic       rd_stat = rd_ap & (a_ofs == SPMP_STAT_OFS);
  wire logic       rd_data = rd_ap & (a_ofs == SPMP_DATA_OFS);
  wire logic       wr_ctrl = wr_r & (addr_r == SPMP_CTRL_OFS);
  wire logic       wr_stat = wr_r & (addr_r == SPMP_STAT_OFS);
  wire logic       wr_data = wr_r & (addr_r == SPMP_DATA_OFS);
  wire logic       stat_acc = rd_stat | wr_stat;
  wire logic [7:0] wdat    = hwdata[7:0];

  // Synchronised pins; only stage two is read
  wire logic [3:0] pin_raw = pin_i;
  wire logic       sck_s   = sync2_r[3];
  wire logic       mosi_s  = sync2_r[2];
  wire logic       miso_s  = sync2_r[1];
  wire logic       ss_s    = sync2_r[0];

  wire logic en     = ctrl_r[SPMP_CTL_EN];
  wire logic ctl    = ctrl_r[SPMP_CTL_CTRL];
  wire logic clock_idle_level   = ctrl_r[SPMP_CTL_CLOCK_IDLE_LEVEL];
  wire logic capture_phase   = ctrl_r[SPMP_CTL_CAPTURE_PHASE];
  wire logic is_ctl = en & ctl;
  wire logic is_tgt = en & ~ctl;
  wire logic run    = (state_r == SPMP_RUN);
  wire logic tgt_on = is_tgt & ~ss_s;

  // Controller loses the port as soon as select drops
  wire logic fault = is_ctl & ~ss_s;

  // Rate code only matters to the controller
  wire logic [1:0] rate = {ctrl_r[SPMP_CTL_RATE_HI], ctrl_r[SPMP_CTL_RATE_LO]};
  wire logic [7:0] half_sel =
    (rate == 2'h0) ? SPMP_HALF_R0 :
    (rate == 2'h1) ? SPMP_HALF_R1 :
    (rate == 2'h2) ? SPMP_HALF_R2 : SPMP_HALF_R3;
  wire logic [7:0] half_ld = half_sel - 8'h01;

  // Edge sources: own divider or received clock
  wire logic ctl_edge = run & (half_cnt_r == 8'h00);
  wire logic tgt_edge = tgt_on & (sck_s ^ sck_d_r);
  wire logic edge_ev  = ctl_edge | tgt_edge;
  wire logic [4:0] edge_no = edge_cnt_r + 5'h01;

  // Phase clear: odd edges capture; phase set: even edges capture
  wire logic capture = edge_ev & (edge_no[0] ^ capture_phase);
  wire logic launch  = edge_ev & ~capture;
  wire logic last    = edge_ev & (edge_no == SPMP_EDGES);

  wire logic       din      = ctl ? miso_s : mosi_s;
  wire logic [7:0] shift_cap = {shift_r[6:0], din};
  wire logic [7:0] rx_cap   = capture ? shift_cap : shift_r;

  // First-edge capture freezes the target as soon as it is selected
  wire logic busy    = run | (tgt_on & (~capture_phase | (edge_cnt_r != 5'h00)));
  wire logic blocked = done_r & ~seen_r;
  wire logic load    = wr_data & ~blocked & ~busy;
  wire logic write_clash_flag_ev = wr_data & ~blocked & busy;
  wire logic start   = load & is_ctl & ss_s;
  wire logic flag_clr = rd_data & seen_r;

  // Enable and mode bits may not be set while a fault is unacknowledged
  wire logic [7:0] lock_mask = (8'h01 << SPMP_CTL_EN) | (8'h01 << SPMP_CTL_CTRL);
  wire logic       lock      = controller_fault_flag_r & ~controller_fault_flag_arm_r;

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = lock ? ((wdat & ~lock_mask) | (ctrl_r & lock_mask)) : wdat;
    end
    if (fault) begin
      ctrl_nxt = ctrl_nxt & ~lock_mask;
    end
  end

  wire logic [7:0] stat_val =
    ({7'h00, done_r} << SPMP_ST_DONE) |
    ({7'h00, write_clash_flag_r} << SPMP_ST_WRITE_CLASH_FLAG) |
    ({7'h00, controller_fault_flag_r} << SPMP_ST_CONTROLLER_FAULT_FLAG);
  wire logic [7:0] rd_mux =
    (a_ofs == SPMP_CTRL_OFS) ? ctrl_r :
    (a_ofs == SPMP_STAT_OFS) ? stat_val :
    (a_ofs == SPMP_DATA_OFS) ? rxbuf_r : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= 4'hF;
      sync2_r <= 4'hF;
      sck_d_r <= 1'b1; // Same level as the sync reset: no false edge
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      sck_d_r <= sck_s;
    end
  end

  // Zero-wait slave: read data is fetched in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r  <= 8'h00;
      wr_r    <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      addr_r <= a_ofs;
      wr_r   <= ap & hwrite;
      if (rd_ap) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // Flags: a setting event wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r     <= SPMP_CTRL_RST;
      done_r     <= 1'b0;
      write_clash_flag_r     <= 1'b0;
      controller_fault_flag_r     <= 1'b0;
      seen_r     <= 1'b0;
      controller_fault_flag_arm_r <= 1'b0;
      rxbuf_r    <= SPMP_DATA_RST;
    end else begin
      ctrl_r     <= ctrl_nxt;
      done_r     <= last | (done_r & ~flag_clr);
      write_clash_flag_r     <= write_clash_flag_ev | (write_clash_flag_r & ~flag_clr);
      controller_fault_flag_r     <= fault | (controller_fault_flag_r & ~(wr_ctrl & controller_fault_flag_arm_r));
      seen_r     <= ~last & ~rd_data & (seen_r | (stat_acc & (done_r | write_clash_flag_r)));
      controller_fault_flag_arm_r <= ~wr_ctrl & (controller_fault_flag_arm_r | (stat_acc & controller_fault_flag_r));
      if (last) begin
        rxbuf_r <= rx_cap;
      end
    end
  end

  // Shift path shared by both modes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_r    <= SPMP_DATA_RST;
      out_bit_r  <= 1'b0;
      edge_cnt_r <= 5'h00;
    end else begin
      if (load) begin
        shift_r   <= wdat;
        out_bit_r <= wdat[7];
      end else begin
        if (capture) begin
          shift_r <= shift_cap;
        end
        if (launch) begin
          out_bit_r <= shift_r[7];
        end
      end
      if (last || (!run && !tgt_on) || fault) begin
        edge_cnt_r <= 5'h00;
      end else if (edge_ev) begin
        edge_cnt_r <= edge_no;
      end
    end
  end

  // Controller clock generator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r    <= SPMP_IDLE;
      half_cnt_r <= 8'h00;
      sck_r      <= 1'b0;
    end else begin
      unique case (state_r)
        SPMP_IDLE: begin
          sck_r      <= clock_idle_level;
          half_cnt_r <= half_ld;
          if (start) begin
            state_r <= SPMP_RUN;
          end
        end
        SPMP_RUN: begin
          if (fault || last) begin
            state_r <= SPMP_IDLE;
            sck_r   <= clock_idle_level;
          end else if (ctl_edge) begin
            sck_r      <= ~sck_r;
            half_cnt_r <= half_ld;
          end else begin
            half_cnt_r <= half_cnt_r - 8'h01;
          end
        end
      endcase
    end
  end

  assign hrdata    = {24'h000000, rdata_r};
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  assign irq = ~irq_mask_i & ctrl_r[SPMP_CTL_IRQ_EN] & (done_r | controller_fault_flag_r);

  // Pins owned by the port only while enabled
  always_comb begin
    pin_o.sck_o   = sck_r;
    pin_o.sck_oe  = is_ctl;
    pin_o.mosi_o  = out_bit_r;
    pin_o.mosi_oe = is_ctl;
    pin_o.miso_o  = out_bit_r;
    pin_o.miso_oe = tgt_on;
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_load;
    load |=> (shift_r == $past(wdat)) && (out_bit_r == $past(wdat[7]));
  endproperty
  a_load: assert property (p_load)
    else $error("data write did not load the shift register");

  property p_eight;
    last |=> (edge_cnt_r == 5'h00) && (sck_r == $past(clock_idle_level));
  endproperty
  a_eight: assert property (p_eight)
    else $error("byte ended with clock off idle level or count not restarted");

  property p_done;
    last |=> done_r ##1 (done_r || $past(flag_clr));
  endproperty
  a_done: assert property (p_done)
    else $error("done flag not set at byte end");

  property p_rxbuf;
    last |=> (rxbuf_r == $past(rx_cap)) ##1 $stable(rxbuf_r);
  endproperty
  a_rxbuf: assert property (p_rxbuf)
    else $error("received byte not buffered");

  property p_blocked;
    (wr_data && blocked && !edge_ev) |=> $stable(shift_r) && !write_clash_flag_r || $past(write_clash_flag_r);
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("write accepted while done flag pending");

  property p_clash;
    (write_clash_flag_ev && !flag_clr) |=> write_clash_flag_r && (state_r == $past(state_r) || $past(last || fault));
  endproperty
  a_clash: assert property (p_clash)
    else $error("clashing write not flagged");

  property p_fault;
    fault |=> controller_fault_flag_r && !ctrl_r[SPMP_CTL_EN] && !ctrl_r[SPMP_CTL_CTRL] ##1 !run;
  endproperty
  a_fault: assert property (p_fault)
    else $error("select low did not fault the controller");

  property p_clear;
    (done_r && !seen_r && rd_data) |=> done_r;
  endproperty
  a_clear: assert property (p_clear)
    else $error("done flag cleared without status access");

  property p_quiet;
    (is_tgt && ss_s) |-> !pin_o.miso_oe && !edge_ev;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("unselected target took part in a transfer");

endmodule

// >>> spmp_pkg.sv
/*
  Constants and carrier types of the byte-wide serial port.
  Assumes a 32-bit AHB-Lite register bus and one clock, hclk.
*/
package spmp_pkg;

  // Register byte offsets
  localparam logic [7:0] SPMP_CTRL_OFS = 8'h00;
  localparam logic [7:0] SPMP_STAT_OFS = 8'h04;
  localparam logic [7:0] SPMP_DATA_OFS = 8'h08;

  // Control field positions
  localparam int SPMP_CTL_IRQ_EN  = 7;
  localparam int SPMP_CTL_EN      = 6;
  localparam int SPMP_CTL_CTRL    = 4;
  localparam int SPMP_CTL_CLOCK_IDLE_LEVEL    = 3;
  localparam int SPMP_CTL_CAPTURE_PHASE    = 2;
  localparam int SPMP_CTL_RATE_HI = 1;
  localparam int SPMP_CTL_RATE_LO = 0;

  // Status field positions
  localparam int SPMP_ST_DONE = 7;
  localparam int SPMP_ST_WRITE_CLASH_FLAG = 6;
  localparam int SPMP_ST_CONTROLLER_FAULT_FLAG = 4;

  // Reset values
  localparam logic [7:0] SPMP_CTRL_RST = 8'h00;
  localparam logic [7:0] SPMP_DATA_RST = 8'h00;

  // Half serial-clock period in hclk cycles, per rate code;
  // at least 3, as the returned data line passes two sync stages
  localparam logic [7:0] SPMP_HALF_R0 = 8'h04;
  localparam logic [7:0] SPMP_HALF_R1 = 8'h08;
  localparam logic [7:0] SPMP_HALF_R2 = 8'h10;
  localparam logic [7:0] SPMP_HALF_R3 = 8'h20;

  // Clock edges in one byte: eight pulses
  localparam logic [4:0] SPMP_EDGES = 5'h10;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } spmp_pin_in_type;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } spmp_pin_out_type;

  typedef enum logic {SPMP_IDLE, SPMP_RUN} spmp_state_type;

endpackage

// >>> spmp_peer.sv
/*
  Far-side serial peer: a target while the port is controller, a
  controller (task xfer) otherwise. Assumes the bench resolves the lines.
*/
`timescale 1ns/100ps

module spmp_peer (
  input  wire logic       hclk,
  input  wire logic       ctl_mode,
  input  wire logic       clock_idle_level,
  input  wire logic       capture_phase,
  input  wire logic       sck_w,
  input  wire logic       mosi_w,
  input  wire logic       miso_w,
  output logic            sck_d,
  output logic            mosi_d,
  output logic            miso_d,
  output logic            ss_n_d,
  output logic [7:0]      rx_r
);
  logic [7:0] tx_r;
  logic       lead;

  initial begin
    sck_d = 1'b0;
    mosi_d = 1'b0;
    miso_d = 1'b0;
    ss_n_d = 1'b1;
    rx_r = 8'h00;
    tx_r = 8'h00;
  end

  // Target role: capture and shift edges follow the shared mode bits
  always @(sck_w) begin
    if (!ctl_mode) begin
      lead = (sck_w !== clock_idle_level);
      if (lead ^ capture_phase) begin
        rx_r = {rx_r[6:0], mosi_w};
      end else if (capture_phase) begin
        miso_d = tx_r[7];
        tx_r = {tx_r[6:0], 1'b0};
      end else begin
        tx_r = {tx_r[6:0], 1'b0};
        miso_d = tx_r[7];
      end
    end
  end

  task automatic load(input logic [7:0] b);
    tx_r = b;
    miso_d = capture_phase ? ~b[7] : b[7];
  endtask

  // Select low over the whole byte, raised after it
  task automatic xfer(input logic [7:0] b, input int hp, input logic sel);
    tx_r = b;
    @(posedge hclk);
    sck_d <= clock_idle_level;
    repeat (hp) @(posedge hclk);
    ss_n_d <= ~sel;
    for (int i = 0; i < 8; i++) begin
      if (!capture_phase)
        mosi_d <= tx_r[7];
      // Half period of hp cycles keeps the clock under half hclk
      repeat (hp) @(posedge hclk);
      sck_d <= ~clock_idle_level;
      if (capture_phase)
        mosi_d <= tx_r[7];
      else
        rx_r <= {rx_r[6:0], miso_w};
      repeat (hp) @(posedge hclk);
      sck_d <= clock_idle_level;
      if (capture_phase)
        rx_r <= {rx_r[6:0], miso_w};
      tx_r = {tx_r[6:0], 1'b0};
    end
    repeat (hp) @(posedge hclk);
    ss_n_d <= 1'b1;
    mosi_d <= ~mosi_d;
  endtask
endmodule

// >>> tb_top.sv
/*
  Self-checking bench of the serial port: registers, controller and
  target bytes against spmp_peer, fault. Assumes spmp_pkg compiled first.
*/
`timescale 1ns/100ps

module tb_top;
  import spmp_pkg::*;

  logic             hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]      haddr, hwdata, hrdata;
  logic [1:0]       htrans;
  logic             irq_mask, irq, peer_ctl, tb_ss_n, clock_idle_level, capture_phase;
  logic             sck_d, mosi_d, miso_d, ss_n_d, sck_q;
  logic [7:0]       peer_rx;
  spmp_pin_in_type  pin_in;
  spmp_pin_out_type pin_out;
  int               edges, cyc, last_e, miscompares, checked, seed;

  assign pin_in = {pin_out.sck_oe ? pin_out.sck_o : sck_d,
                   pin_out.mosi_oe ? pin_out.mosi_o : mosi_d,
                   pin_out.miso_oe ? pin_out.miso_o : miso_d,
                   peer_ctl ? ss_n_d : tb_ss_n};

  spmp_port i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_mask_i(irq_mask),
    .irq(irq), .pin_i(pin_in), .pin_o(pin_out));

  spmp_peer i_peer (.hclk(hclk), .ctl_mode(peer_ctl), .clock_idle_level(clock_idle_level), .capture_phase(capture_phase),
    .sck_w(pin_in.sck), .mosi_w(pin_in.mosi), .miso_w(pin_in.miso), .sck_d(sck_d),
    .mosi_d(mosi_d), .miso_d(miso_d), .ss_n_d(ss_n_d), .rx_r(peer_rx));

  always #20 hclk = ~hclk;

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    sck_q <= pin_in.sck;
    if (pin_in.sck !== sck_q) begin
      edges <= edges + 1;
      last_e <= cyc;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    q = hrdata[7:0];
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    ahb(1'b0, a, 8'h00, q);
    chk(nm, {hresp, q}, {1'b0, exp});
  endtask

  function automatic int hp_of(input logic [1:0] r);
    return r == 2'h0 ? SPMP_HALF_R0 : r == 2'h1 ? SPMP_HALF_R1 :
           r == 2'h2 ? SPMP_HALF_R2 : SPMP_HALF_R3;
  endfunction

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge hclk);
    miscompares++;
    end_sim();
  end

  initial begin
    logic [7:0] tx, pb, ctl, rv;
    int         e0, t0, hp;
    {hclk, hresetn, hsel, hwrite, clock_idle_level, capture_phase, peer_ctl, sck_q} = 8'h00;
    {haddr, hwdata, htrans} = 66'h0;
    irq_mask = 1'b1;
    tb_ss_n = 1'b1;
    {edges, cyc, last_e, miscompares, checked} = 160'h0;
    seed = 91;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk("ctrl reset", SPMP_CTRL_OFS, SPMP_CTRL_RST);
    rdchk("status reset", SPMP_STAT_OFS, 8'h00);
    ahb(1'b1, 8'h0C, 8'hFF, rv);
    rdchk("unmapped", 8'h0C, 8'h00);
    $display("registers test done");
    for (int k = 0; k < 8; k++) begin
      tx = 8'($random(seed));
      pb = 8'($random(seed));
      ctl = 8'($random(seed));
      ctl[SPMP_CTL_EN] = 1'b1;
      ctl[SPMP_CTL_CTRL] = 1'b1;
      ctl[SPMP_CTL_CLOCK_IDLE_LEVEL] = k[2];
      ctl[SPMP_CTL_CAPTURE_PHASE] = k[0];
      ctl[1:0] = k[1:0];
      hp = hp_of(k[1:0]);
      irq_mask <= 1'($random(seed));
      clock_idle_level <= k[2];
      capture_phase <= k[0];
      ahb(1'b1, SPMP_CTRL_OFS, ctl, rv);
      repeat (4) @(posedge hclk);
      chk("ctl enables", {pin_out.sck_oe, pin_out.mosi_oe, pin_out.miso_oe}, 3'h6);
      i_peer.load(pb);
      e0 = edges;
      ahb(1'b1, SPMP_DATA_OFS, tx, rv);
      t0 = cyc;
      // Lands mid-byte: must be dropped
      ahb(1'b1, SPMP_DATA_OFS, ~tx, rv);
      for (int n = 0; n < 2000 && edges - e0 < 16; n++)
        @(posedge hclk);
      repeat (4) @(posedge hclk);
      chk("edge count", edges - e0, 16);
      chk("byte time", last_e - t0 >= 16 * hp && last_e - t0 <= 16 * hp + 3, 1);
      chk("peer rx", peer_rx, tx);
      chk("irq", irq, ctl[SPMP_CTL_IRQ_EN] & ~irq_mask);
      ahb(1'b1, SPMP_DATA_OFS, 8'h5A, rv);
      rdchk("status", SPMP_STAT_OFS, 8'hC0);
      rdchk("rx byte", SPMP_DATA_OFS, pb);
      rdchk("status clear", SPMP_STAT_OFS, 8'h00);
      repeat (2 * hp + 4) @(posedge hclk);
      chk("blocked write", edges - e0, 16);
    end
    $display("controller test done");
    peer_ctl <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      tx = 8'($random(seed));
      pb = 8'($random(seed));
      ctl = 8'($random(seed));
      ctl[SPMP_CTL_EN] = 1'b1;
      ctl[SPMP_CTL_CTRL] = 1'b0;
      ctl[SPMP_CTL_CLOCK_IDLE_LEVEL] = k[1];
      ctl[SPMP_CTL_CAPTURE_PHASE] = k[0];
      irq_mask <= 1'($random(seed));
      clock_idle_level <= k[1];
      capture_phase <= k[0];
      ahb(1'b1, SPMP_CTRL_OFS, ctl, rv);
      ahb(1'b1, SPMP_DATA_OFS, tx, rv);
      chk("tgt enables", {pin_out.sck_oe, pin_out.mosi_oe, pin_out.miso_oe}, 3'h0);
      i_peer.xfer(pb, 6, 1'b1);
      repeat (4) @(posedge hclk);
      chk("tgt peer rx", peer_rx, tx);
      chk("tgt irq", irq, ctl[SPMP_CTL_IRQ_EN] & ~irq_mask);
      rdchk("tgt status", SPMP_STAT_OFS, 8'h80);
      rdchk("tgt rx byte", SPMP_DATA_OFS, pb);
      rdchk("tgt clear", SPMP_STAT_OFS, 8'h00);
    end
    i_peer.xfer(8'hA5, 6, 1'b0);
    rdchk("unselected", SPMP_STAT_OFS, 8'h00);
    rdchk("unselected rx", SPMP_DATA_OFS, pb);
    $display("target test done");
    peer_ctl <= 1'b0;
    irq_mask <= 1'b0;
    ahb(1'b1, SPMP_CTRL_OFS, 8'hD0, rv);
    tb_ss_n <= 1'b0;
    repeat (6) @(posedge hclk);
    chk("fault irq", irq, 1'b1);
    chk("fault outputs", {pin_out.sck_oe, pin_out.mosi_oe}, 2'h0);
    rdchk("fault status", SPMP_STAT_OFS, 8'h10);
    rdchk("fault ctrl", SPMP_CTRL_OFS, 8'h80);
    tb_ss_n <= 1'b1;
    ahb(1'b1, SPMP_CTRL_OFS, 8'h00, rv);
    rdchk("fault clear", SPMP_STAT_OFS, 8'h00);
    $display("fault test done");
    end_sim();
  end
endmodule
